//--- hdl/cell_storage_elements.sv
// Four configurable storage elements of a function unit, AXI4-Lite configured
//
// Operation
// - Each element is a latch or edge flip-flop, positive or negative sense.
// - All four elements share one cell clock, optionally inverted unit-wide.
// - Data comes from table result or direct input, chosen for all four.
// - Any stored bit can be steered onto any of the five outputs.
// - Inactive enable holds flip-flops; asynchronous set/reset still acts.
// - Enable and local set/reset inputs may each be inverted active-low.
// - Synchronous local set/reset acts on flip-flops at active edge only while enabled.
// - Enable applies to flip-flops only, as a hold-or-load mux.
// - Global set/reset is asynchronous and forces every configured value.
// - Per-element bit chooses set or reset for both global and local.
// - Unit runs synchronous, asynchronous, or front-end select mode.
// - In front-end select mode local set/reset chooses data source.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cell_storage_elements (
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [cell_storage_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cell_storage_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cell_storage_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cell_storage_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Function unit side
  input wire logic cellClock,
  input wire logic clockEnable,
  input wire logic localSetReset,
  input wire logic globalSetResetN,
  input wire logic [cell_storage_pkg::NUM_ELEMENTS-1:0] lutResult,
  input wire logic [cell_storage_pkg::NUM_ELEMENTS-1:0] directDataIn,
  output logic [cell_storage_pkg::NUM_ELEMENTS-1:0] storedQ,
  output logic [cell_storage_pkg::NUM_OUTPUTS-1:0] unitOut
);

  localparam int NE = cell_storage_pkg::NUM_ELEMENTS;
  localparam int NO = cell_storage_pkg::NUM_OUTPUTS;
  localparam int SW = cell_storage_pkg::SEL_W;
  localparam int AW = cell_storage_pkg::AXI_ADDR_W;
  localparam int DW = cell_storage_pkg::AXI_DATA_W;

  // ---------------- Configuration registers ----------------
  cell_storage_pkg::cfg_t cfg;
  cell_storage_pkg::cfg_t next_cfg;

  // ---------------- AXI write channel state ----------------
  logic awHeld;
  logic wHeld;
  logic [AW-1:0] awAddr;
  logic [DW-1:0] wData;
  logic [3:0] wStrb;
  logic awTaken;
  logic wTaken;
  logic bTaken;
  logic doWrite;

  assign awTaken = s_axi_awvalid && s_axi_awready;
  assign wTaken = s_axi_wvalid && s_axi_wready;
  assign bTaken = s_axi_bvalid && s_axi_bready;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      s_axi_awready <= 1'b0;
    end else if (awTaken) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (bTaken || (!awHeld && !s_axi_bvalid)) begin
      awHeld <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
      s_axi_wready <= 1'b0;
    end else if (wTaken) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (bTaken || (!wHeld && !s_axi_bvalid)) begin
      wHeld <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write decode on the word address; low two bits ignored
  logic [AW-1:0] wordAddrW;
  logic hitCtrlW;
  logic hitElemW;
  logic hitOutselW;
  logic hitStatusW;
  logic mappedW;
  logic [DW-1:0] byteMask;

  assign wordAddrW = {awAddr[AW-1:2], 2'b00};
  assign hitCtrlW = (wordAddrW == cell_storage_pkg::CTRL_OFFSET);
  assign hitElemW = (wordAddrW == cell_storage_pkg::ELEM_OFFSET);
  assign hitOutselW = (wordAddrW == cell_storage_pkg::OUTSEL_OFFSET);
  assign hitStatusW = (wordAddrW == cell_storage_pkg::STATUS_OFFSET);
  assign mappedW = hitCtrlW || hitElemW || hitOutselW || hitStatusW;
  assign byteMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cell_storage_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mappedW ? cell_storage_pkg::RESP_OKAY : cell_storage_pkg::RESP_SLVERR;
    end else if (bTaken) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- Register words ----------------
  logic [DW-1:0] ctrlWord;
  logic [DW-1:0] elemWord;
  logic [DW-1:0] outselWord;
  logic [DW-1:0] statusWord;

  assign ctrlWord = {{(DW - cell_storage_pkg::CTRL_USED_W){1'b0}},
                     cfg.sourceDirect, cfg.lsrInvert, cfg.ceInvert,
                     cfg.clockInvert, cfg.lsrMode};
  assign elemWord = {{(DW - cell_storage_pkg::ELEM_USED_W){1'b0}}, cfg.setValue, cfg.latchMode};
  assign outselWord = {{(DW - cell_storage_pkg::OUTSEL_USED_W){1'b0}}, cfg.outSel};
  assign statusWord = {{(DW - cell_storage_pkg::STATUS_USED_W){1'b0}}, unitOut, storedQ};

  // Byte-masked merge of the written data into the current word
  logic [DW-1:0] ctrlMerged;
  logic [DW-1:0] elemMerged;
  logic [DW-1:0] outselMerged;
  logic [1:0] mergedMode;
  logic modeLegal;

  assign ctrlMerged = (ctrlWord & ~byteMask) | (wData & byteMask);
  assign elemMerged = (elemWord & ~byteMask) | (wData & byteMask);
  assign outselMerged = (outselWord & ~byteMask) | (wData & byteMask);
  assign mergedMode = ctrlMerged[cell_storage_pkg::CTRL_MODE_LSB +: 2];
  // The fourth mode code has no meaning; such a write keeps the old mode
  assign modeLegal = (mergedMode == cell_storage_pkg::MODE_SYNC) ||
                     (mergedMode == cell_storage_pkg::MODE_ASYNC) ||
                     (mergedMode == cell_storage_pkg::MODE_FRONT);

  always_comb begin
    next_cfg = cfg;
    if (doWrite && hitCtrlW) begin
      if (modeLegal) begin
        next_cfg.lsrMode = mergedMode;
      end
      next_cfg.clockInvert = ctrlMerged[cell_storage_pkg::CTRL_CLKINV_BIT];
      next_cfg.ceInvert = ctrlMerged[cell_storage_pkg::CTRL_CEINV_BIT];
      next_cfg.lsrInvert = ctrlMerged[cell_storage_pkg::CTRL_LSRINV_BIT];
      next_cfg.sourceDirect = ctrlMerged[cell_storage_pkg::CTRL_DIRECT_BIT];
    end
    if (doWrite && hitElemW) begin
      next_cfg.latchMode = elemMerged[cell_storage_pkg::ELEM_LATCH_LSB +: NE];
      next_cfg.setValue = elemMerged[cell_storage_pkg::ELEM_SETVAL_LSB +: NE];
    end
    if (doWrite && hitOutselW) begin
      next_cfg.outSel = outselMerged[cell_storage_pkg::OUTSEL_USED_W-1:0];
    end
  end

  // Static settings; changing them mid-operation is allowed but not glitch-free
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg.lsrMode <= cell_storage_pkg::MODE_RESET;
      cfg.clockInvert <= 1'b0;
      cfg.ceInvert <= 1'b0;
      cfg.lsrInvert <= 1'b0;
      cfg.sourceDirect <= 1'b0;
      cfg.latchMode <= cell_storage_pkg::LATCH_RESET;
      cfg.setValue <= cell_storage_pkg::SETVAL_RESET;
      cfg.outSel <= cell_storage_pkg::OUTSEL_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ---------------- AXI read channel ----------------
  logic arTaken;
  logic rTaken;
  logic [AW-1:0] wordAddrR;
  logic [DW-1:0] readWord;
  logic mappedR;

  assign arTaken = s_axi_arvalid && s_axi_arready;
  assign rTaken = s_axi_rvalid && s_axi_rready;
  assign wordAddrR = {s_axi_araddr[AW-1:2], 2'b00};
  assign mappedR = (wordAddrR == cell_storage_pkg::CTRL_OFFSET) ||
                   (wordAddrR == cell_storage_pkg::ELEM_OFFSET) ||
                   (wordAddrR == cell_storage_pkg::OUTSEL_OFFSET) ||
                   (wordAddrR == cell_storage_pkg::STATUS_OFFSET);
  assign readWord = (wordAddrR == cell_storage_pkg::CTRL_OFFSET) ? ctrlWord :
                    (wordAddrR == cell_storage_pkg::ELEM_OFFSET) ? elemWord :
                    (wordAddrR == cell_storage_pkg::OUTSEL_OFFSET) ? outselWord :
                    (wordAddrR == cell_storage_pkg::STATUS_OFFSET) ? statusWord : '0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cell_storage_pkg::RESP_OKAY;
    end else if (arTaken) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= mappedR ? cell_storage_pkg::RESP_OKAY : cell_storage_pkg::RESP_SLVERR;
    end else if (rTaken || !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- Shared unit controls ----------------
  logic effClock;
  logic prevClock;
  logic primed;
  logic enableActive;
  logic lsrActive;
  logic modeSync;
  logic modeAsync;
  logic modeFront;
  cell_storage_pkg::element_ctl_t ctl;

  assign effClock = cellClock ^ cfg.clockInvert;
  assign enableActive = clockEnable ^ cfg.ceInvert;
  assign lsrActive = localSetReset ^ cfg.lsrInvert;
  assign modeSync = (cfg.lsrMode == cell_storage_pkg::MODE_SYNC);
  assign modeAsync = (cfg.lsrMode == cell_storage_pkg::MODE_ASYNC);
  assign modeFront = (cfg.lsrMode == cell_storage_pkg::MODE_FRONT);

  // Edge found against the previous sample; the first sample after reset is
  // not trusted, so a clock already high at release makes no false edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prevClock <= 1'b0;
      primed <= 1'b0;
    end else begin
      prevClock <= effClock;
      primed <= 1'b1;
    end
  end

  assign ctl.clockEdge = primed && effClock && !prevClock;
  assign ctl.clockLevel = effClock;
  assign ctl.enable = enableActive;
  assign ctl.syncSr = modeSync && lsrActive;
  assign ctl.asyncSr = modeAsync && lsrActive;
  assign ctl.globalSr = !globalSetResetN;
  // In front-end mode the local input picks direct data when active
  assign ctl.useDirect = modeFront ? lsrActive : cfg.sourceDirect;

  // ---------------- Storage elements and output steering ----------------
  genvar i;
  generate
    for (i = 0; i < NE; i++) begin : g_elem
      storage_element u_elem (
        .clk(clk),
        .resetn(resetn),
        .ctl(ctl),
        .latchMode(cfg.latchMode[i]),
        .setValue(cfg.setValue[i]),
        .lutIn(lutResult[i]),
        .directIn(directDataIn[i]),
        .q(storedQ[i])
      );
    end
    for (i = 0; i < NO; i++) begin : g_out
      output_select #(
        .N(NE),
        .SEL_W(SW)
      ) u_sel (
        .clk(clk),
        .resetn(resetn),
        .q(storedQ),
        .sel(cfg.outSel[i*SW +: SW]),
        .o(unitOut[i])
      );
    end
  endgenerate

endmodule : cell_storage_elements

//--- hdl/cell_storage_pkg.sv
// Constants, register map and carrier types for the cell storage block
package cell_storage_pkg;

  localparam int NUM_ELEMENTS = 4;
  localparam int NUM_OUTPUTS = 5;
  localparam int SEL_W = 2;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // Register byte addresses
  localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] ELEM_OFFSET = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OUTSEL_OFFSET = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h0C;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLKINV_BIT = 2;
  localparam int CTRL_CEINV_BIT = 3;
  localparam int CTRL_LSRINV_BIT = 4;
  localparam int CTRL_DIRECT_BIT = 5;
  localparam int CTRL_USED_W = 6;

  // Element register fields
  localparam int ELEM_LATCH_LSB = 0;
  localparam int ELEM_SETVAL_LSB = 4;
  localparam int ELEM_USED_W = 8;

  // Output select and status fields
  localparam int OUTSEL_USED_W = NUM_OUTPUTS * SEL_W;
  localparam int STATUS_Q_LSB = 0;
  localparam int STATUS_O_LSB = 4;
  localparam int STATUS_USED_W = 9;

  // Storage mode codes of the local set/reset
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC = 2'h1;
  localparam logic [1:0] MODE_FRONT = 2'h2;

  // Reset values
  localparam logic [1:0] MODE_RESET = MODE_SYNC;
  localparam logic [NUM_ELEMENTS-1:0] LATCH_RESET = 4'h0;
  localparam logic [NUM_ELEMENTS-1:0] SETVAL_RESET = 4'h0;
  localparam logic [OUTSEL_USED_W-1:0] OUTSEL_RESET = 10'h0E4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] lsrMode;
    logic clockInvert;
    logic ceInvert;
    logic lsrInvert;
    logic sourceDirect;
    logic [NUM_ELEMENTS-1:0] latchMode;
    logic [NUM_ELEMENTS-1:0] setValue;
    logic [OUTSEL_USED_W-1:0] outSel;
  } cfg_t;

  // Unit-wide controls shared by all four elements
  typedef struct packed {
    logic clockEdge;
    logic clockLevel;
    logic enable;
    logic syncSr;
    logic asyncSr;
    logic globalSr;
    logic useDirect;
  } element_ctl_t;

endpackage : cell_storage_pkg

//--- hdl/output_select.sv
// Registered selector placing one of the stored bits on a unit output
`timescale 1ns/1ps
module output_select #(
  parameter int N = 4,
  parameter int SEL_W = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [N-1:0] q,
  input wire logic [SEL_W-1:0] sel,
  output logic o
);

  logic picked;

  assign picked = q[sel];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      o <= 1'b0;
    end else begin
      o <= picked;
    end
  end

endmodule : output_select

//--- hdl/storage_element.sv
// One latch or flip-flop of the function unit with set/reset handling
`timescale 1ns/1ps
module storage_element (
  input wire logic clk,
  input wire logic resetn,
  input wire cell_storage_pkg::element_ctl_t ctl,
  input wire logic latchMode,
  input wire logic setValue,
  input wire logic lutIn,
  input wire logic directIn,
  output logic q
);

  logic d;
  logic heldOrNew;

  assign d = ctl.useDirect ? directIn : lutIn;
  // Enable is a two-way mux in front of the flip-flop only
  assign heldOrNew = ctl.enable ? d : q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= 1'b0;
    end else if (ctl.globalSr) begin
      q <= setValue;
    end else if (ctl.asyncSr) begin
      q <= setValue;
    end else if (latchMode) begin
      if (ctl.clockLevel) begin
        q <= d;
      end
    end else if (ctl.clockEdge) begin
      if (ctl.syncSr && ctl.enable) begin
        q <= setValue;
      end else begin
        q <= heldOrNew;
      end
    end
  end

endmodule : storage_element

//--- verification/cell_clock_model.sv
// Behavioural cell clock source of the surrounding fabric
`timescale 1ns/1ps
module cell_clock_model #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic go,
  output logic cellClock,
  output logic busy
);
  int cnt = 0;
  initial cellClock = 1'b0;
  initial busy = 1'b0;
  // One pulse per request, clock stands low between requests
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      cellClock <= (cnt < HALF);
      busy <= (cnt < 2 * HALF);
    end
  end
endmodule : cell_clock_model

//--- verification/cell_storage_elements_chk.sv
// Port checker for the cell storage block
`timescale 1ns/1ps
module cell_storage_elements_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cellClock,
  input wire logic clockEnable,
  input wire logic localSetReset,
  input wire logic globalSetResetN,
  input wire logic [3:0] lutResult,
  input wire logic [3:0] directDataIn,
  input wire logic [3:0] storedQ,
  input wire logic [4:0] unitOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Bvalid rises at the edge that loads the config, so a config change is always excluded
  sequence quiet;
    $stable(cellClock) && $stable(clockEnable) && $stable(localSetReset)
      && $stable(globalSetResetN) && $stable(lutResult) && $stable(directDataIn)
      && !s_axi_bvalid;
  endsequence
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !resetn |=> !s_axi_awready && !s_axi_bvalid && storedQ == 4'h0)
    else $error("outputs not idle after reset");
  AST_WRITE_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  AST_B_STANDS: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_W_REFUSED: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_STANDS: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_QUIET_HOLD: assert property (quiet |=> $stable(storedQ))
    else $error("stored bits changed without cause");
  AST_GSR_HOLD: assert property (
    !globalSetResetN ##1 !globalSetResetN |=> $stable(storedQ))
    else $error("stored bits moved under global set/reset");
  AST_OUT_FOLLOW: assert property (
    !s_axi_bvalid && $stable(storedQ) |=> $stable(unitOut))
    else $error("unit output moved without cause");
  cover property (!globalSetResetN ##1 !globalSetResetN);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : cell_storage_elements_chk

bind cell_storage_elements cell_storage_elements_chk chk_i (.clk, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cellClock,
  .clockEnable, .localSetReset, .globalSetResetN, .lutResult, .directDataIn, .storedQ, .unitOut);

//--- verification/cell_storage_elements_tb_top.sv
// Directed testbench for the cell storage block
`timescale 1ns/1ps
module cell_storage_elements_tb_top;
  logic clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic resetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0, clockEnable = 1'b0;
  logic localSetReset = 1'b0, globalSetResetN = 1'b1, cellClock;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] lutResult = 4'h0, directDataIn = 4'h0, storedQ, s_axi_wstrb = 4'hF;
  logic [4:0] unitOut;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [31:0] re [5] = '{32'h0, 32'h0, 32'h0E4, 32'h0, 32'h0};
  logic [1:0] rr [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  int failures = 0, checked = 0;

  cell_storage_elements dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cellClock, .clockEnable, .localSetReset, .globalSetResetN,
    .lutResult, .directDataIn, .storedQ, .unitOut);
  cell_clock_model pm (.clk, .go, .cellClock, .busy);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic qchk(input logic [3:0] e);
    chk("storedQ", {28'h0, e}, {28'h0, storedQ});
  endtask : qchk

  // Response ready is raised late on purpose, to make the slave hold its answer
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : wchk

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : rchk

  task automatic start();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : start

  task automatic fin();
    while (busy) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : fin

  task automatic cp();
    start();
    fin();
  endtask : cp

  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rchk(ra[i], re[i], rr[i]);
    wchk(8'h10, 32'hFF, 2'h2);
    $display("test registers done");
    lutResult <= 4'hA;
    clockEnable <= 1'b1;
    cp();
    qchk(4'hA);
    chk("unitOut", 32'h0A, {27'h0, unitOut});
    clockEnable <= 1'b0;
    lutResult <= 4'h5;
    cp();
    qchk(4'hA);
    wchk(8'h00, 32'h08, 2'h0);
    cp();
    qchk(4'h5);
    wchk(8'h00, 32'h28, 2'h0);
    directDataIn <= 4'h3;
    cp();
    qchk(4'h3);
    wchk(8'h04, 32'hC0, 2'h0);
    localSetReset <= 1'b1;
    cp();
    qchk(4'hC);
    wchk(8'h00, 32'h38, 2'h0);
    cp();
    qchk(4'h3);
    $display("test flip-flop done");
    wchk(8'h00, 32'h01, 2'h0);
    repeat (3) @(posedge clk);
    qchk(4'hC);
    wchk(8'h00, 32'h02, 2'h0);
    directDataIn <= 4'h6;
    lutResult <= 4'h9;
    clockEnable <= 1'b1;
    cp();
    qchk(4'h6);
    localSetReset <= 1'b0;
    cp();
    qchk(4'h9);
    wchk(8'h00, 32'h04, 2'h0);
    lutResult <= 4'h2;
    start();
    qchk(4'h9);
    fin();
    qchk(4'h2);
    $display("test modes done");
    wchk(8'h00, 32'h00, 2'h0);
    wchk(8'h04, 32'h0F, 2'h0);
    clockEnable <= 1'b0;
    lutResult <= 4'h7;
    start();
    qchk(4'h7);
    fin();
    lutResult <= 4'h4;
    repeat (3) @(posedge clk);
    qchk(4'h7);
    wchk(8'h04, 32'hA0, 2'h0);
    globalSetResetN <= 1'b0;
    repeat (3) @(posedge clk);
    qchk(4'hA);
    lutResult <= 4'hF;
    clockEnable <= 1'b1;
    cp();
    qchk(4'hA);
    globalSetResetN <= 1'b1;
    $display("test latch and global done");
    wchk(8'h08, 32'h3FF, 2'h0);
    repeat (3) @(posedge clk);
    chk("unitOut", 32'h1F, {27'h0, unitOut});
    wchk(8'h08, 32'h01B, 2'h0);
    repeat (3) @(posedge clk);
    chk("unitOut", 32'h05, {27'h0, unitOut});
    rchk(8'h0C, 32'h05A, 2'h0);
    // Only byte lane 1 written: out4 select merges onto the old word
    s_axi_wstrb <= 4'h2;
    wchk(8'h08, 32'h300, 2'h0);
    s_axi_wstrb <= 4'hF;
    rchk(8'h08, 32'h31B, 2'h0);
    chk("unitOut", 32'h15, {27'h0, unitOut});
    // Meaningless mode code keeps the old mode
    wchk(8'h00, 32'h03, 2'h0);
    rchk(8'h00, 32'h00, 2'h0);
    $display("test outputs done");
    end_sim();
  end
endmodule : cell_storage_elements_tb_top
